// ### hdl/mcwd_top.sv
/*
  motion command word decoder: takes the ten-word output image one word per
  strobe, commits it on a frame strobe, validates configuration data,
  detects command edges and raises one-cycle command pulses; also forms the
  two reported position words in the selected format.
  assumes the host writes words 0..9 then pulses frame_commit_i, and that the
  board provides encoder type and position inputs synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1: status bit 13 shows stall enable in config mode, config error in command mode.
// RULE2: any reserved bit set in configuration words makes configuration invalid.
// RULE3: out-of-range parameter, starting speed low word above 999, is invalid.
// RULE4: resolution 2048 only for absolute; 1024, 2048, 4096 for incremental.
// RULE5: two inputs with same non-general-purpose function are invalid.
// RULE6: stall detection enabled without encoder in use is invalid.
// RULE7: input function code 111 is invalid.
// RULE8: each direction carries ten 16-bit words.
// RULE9: default two-word format: value divided by 1000, then signed remainder.
// RULE10: two-word range -32768000..32767999; overflow gives indeterminate words.
// RULE11: format bits choose encoding; endian clear puts low word first.
// RULE12: a command fires only on a zero-to-one change between writes.
// RULE13: edge history persists across a configuration to command mode change.
// RULE14: host raises at most one command word 0 bit per write.
// RULE15: word 0 is command word 0, word 1 command word 1, rest parameters.
// RULE16: word 0 bit 15 set selects configuration mode, clear command mode.
// RULE17: rising bit 14 loads encoder position from words 2 and 3.
// RULE18: rising bit 13 runs stored sequence; bit 9 picks blend or dwell, word 9 dwell.
// RULE19: word 1 bit 4 picks blend direction, zero clockwise.
// RULE20: rising bit 10 clears command errors, input error, move complete only.
// RULE21: rising bit 9 presets position from words or feedback, clears complete and invalid.
// RULE22: rising bit 8 jogs ccw, registration if bit 7, follower if bit 12 or 14.
// RULE23: invalid configuration keeps command mode and sets configuration error.
// RULE24: more than one rising command bit is ignored and flagged as command error.
// RULE25: previous command bits are stored on every accepted write.
module mcwd_top
  import mcwd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic word_wr_i,
  input wire logic [3:0] word_idx_i,
  input wire logic [15:0] word_data_i,
  input wire logic frame_commit_i,
  input wire logic enc_absolute_i,
  input wire logic move_done_i,
  input wire logic input_fault_i,
  input wire logic signed [31:0] motor_pos_i,
  output logic cfg_mode_o,
  output logic cfg_error_o,
  output logic cmd_error_o,
  output logic input_error_o,
  output logic move_complete_o,
  output logic pos_invalid_o,
  output logic [15:0] status_word0_o,
  output logic [15:0] pos_word_first_o,
  output logic [15:0] pos_word_second_o,
  output logic out_fmt_32_o,
  output logic in_fmt_32_o,
  output logic big_endian_o,
  output logic load_from_feedback_o,
  output logic run_stored_sequence_o,
  output logic seq_dwell_o,
  output logic seq_ccw_o,
  output logic [15:0] dwell_ms_o,
  output logic clear_errors_o,
  output logic preset_position_o,
  output logic preset_src_fb_o,
  output logic jog_counterclockwise_o,
  output logic jog_registration_o,
  output logic axis_follower_o,
  output logic [31:0] param_value_o
);
////////////////////////////////////////////////////////////////////////////////
// word image
  logic [15:0] w [MCWD_NUM_WORDS];
  logic [15:0] prev_cmd0;
  logic stall_en;

  function automatic logic [2:0] func_of(input logic [15:0] c0, input int unsigned lsb);
    func_of = c0[lsb +: 3];
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < MCWD_NUM_WORDS; i++) begin
        w[i] <= 16'h0000;
      end
    end else if (word_wr_i && (word_idx_i < 4'hA)) begin
      w[word_idx_i] <= word_data_i; // RULE8
    end
  end

  // keeps the last word 0 written with the mode bit set, for the config mode mirror
  logic [15:0] cfg_mirror_rd;
  mcwd_word_mem u_cfg_mem (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(word_wr_i && (word_idx_i == MCWD_IDX_CMD0) && word_data_i[MCWD_B0_MODE]), // RULE1
    .wr_idx_i(word_idx_i),
    .wr_data_i(word_data_i),
    .rd_idx_i(MCWD_IDX_CMD0),
    .rd_data_o(cfg_mirror_rd)
  );

////////////////////////////////////////////////////////////////////////////////
// configuration checks
  wire [15:0] c0 = w[MCWD_IDX_CMD0];
  wire [15:0] c1 = w[MCWD_IDX_CMD1];
  wire [15:0] spd_lo = w[MCWD_IDX_SPD_LO];
  wire [15:0] enc_res = w[MCWD_IDX_ENC_RES];
  wire [2:0] f1 = func_of(c0, MCWD_C0_IN1_LSB);
  wire [2:0] f2 = func_of(c0, MCWD_C0_IN2_LSB);
  wire enc_use = c0[MCWD_C0_ENC_USE];
  wire bad_rsv = |(c0 & MCWD_C0_RSV_MASK) || |(c1 & MCWD_C1_RSV_MASK); // RULE2
  wire bad_spd = spd_lo > MCWD_SPD_LO_MAX; // RULE3
  wire res_abs_ok = enc_res == MCWD_RES_2K;
  wire res_inc_ok = (enc_res == MCWD_RES_1K) || (enc_res == MCWD_RES_2K) ||
                    (enc_res == MCWD_RES_4K);
  wire bad_res = enc_use && (enc_absolute_i ? !res_abs_ok : !res_inc_ok); // RULE4
  wire bad_dup = (f1 == f2) && (f1 != MCWD_FUNC_GP); // RULE5
  wire bad_stall = c0[MCWD_C0_STALL] && !enc_use; // RULE6
  wire bad_code = (f1 == MCWD_FUNC_BAD) || (f2 == MCWD_FUNC_BAD); // RULE7
  wire cfg_bad = bad_rsv || bad_spd || bad_res || bad_dup || bad_stall || bad_code;
  wire want_cfg = c0[MCWD_B0_MODE]; // RULE16

////////////////////////////////////////////////////////////////////////////////
// edge detection
  wire [14:0] rise = c0[14:0] & ~prev_cmd0[14:0]; // RULE12
  wire one_rise = (rise != 15'h0000) && ((rise & (rise - 15'h0001)) == 15'h0000);
  wire multi_rise = (rise != 15'h0000) && !one_rise; // RULE24
  wire cmd_ok = frame_commit_i && !want_cfg && one_rise;
  wire go_load = cmd_ok && rise[MCWD_B0_LOAD_FB]; // RULE17
  wire go_run = cmd_ok && rise[MCWD_B0_RUN_SEQ]; // RULE18
  wire go_clr = cmd_ok && rise[MCWD_B0_CLR_ERR]; // RULE20
  wire go_pre = cmd_ok && rise[MCWD_B0_PRESET]; // RULE21
  wire go_jog = cmd_ok && rise[MCWD_B0_JOG_COUNTERCLOCKWISE]; // RULE22
  wire reg_mv = c1[MCWD_B1_REG_MOVE];
  wire follow = !reg_mv && (c1[MCWD_B1_POS_FOLLOW] || c1[MCWD_B1_ENC_FOLLOW]); // RULE22
  wire [31:0] par32 = {w[MCWD_IDX_PAR_HI], w[MCWD_IDX_PAR_LO]};

////////////////////////////////////////////////////////////////////////////////
// reported position encoding
  wire signed [31:0] q = motor_pos_i / MCWD_SCALE;
  wire signed [31:0] r = motor_pos_i - q * MCWD_SCALE; // RULE9
  wire pos_ovf = (motor_pos_i < MCWD_MW_MIN) || (motor_pos_i > MCWD_MW_MAX); // RULE10
  wire [15:0] mw_first = pos_ovf ? MCWD_IND_WORD : q[15:0];
  wire [15:0] mw_second = pos_ovf ? MCWD_IND_WORD : r[15:0];
  wire [15:0] b_first = big_endian_o ? motor_pos_i[31:16] : motor_pos_i[15:0]; // RULE11
  wire [15:0] b_second = big_endian_o ? motor_pos_i[15:0] : motor_pos_i[31:16];
  wire [15:0] next_status0 = {cfg_mode_o, 1'b0,
                              cfg_mode_o ? stall_en : cfg_error_o, // RULE1
                              cmd_error_o, input_error_o, move_complete_o,
                              pos_invalid_o, 9'h000};

////////////////////////////////////////////////////////////////////////////////
// state
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_cmd0 <= 16'h0000;
      cfg_mode_o <= 1'b0;
      cfg_error_o <= 1'b0;
      stall_en <= 1'b0;
      out_fmt_32_o <= 1'b0;
      in_fmt_32_o <= 1'b0;
      big_endian_o <= 1'b0;
    end else if (frame_commit_i) begin
      prev_cmd0 <= c0; // RULE25 RULE13
      if (want_cfg && !cfg_bad) begin
        cfg_mode_o <= 1'b1;
        cfg_error_o <= 1'b0;
        stall_en <= c0[MCWD_C0_STALL];
        in_fmt_32_o <= c1[MCWD_B1_INFMT]; // RULE11
        out_fmt_32_o <= c1[MCWD_B1_OUTFMT];
        big_endian_o <= c1[MCWD_B1_ENDIAN];
      end else begin
        cfg_mode_o <= 1'b0; // RULE23
        cfg_error_o <= cfg_error_o | (want_cfg & cfg_bad); // RULE23
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_error_o <= 1'b0;
      input_error_o <= 1'b0;
      move_complete_o <= 1'b0;
      pos_invalid_o <= 1'b0;
    end else begin
      cmd_error_o <= (cmd_error_o && !go_clr) ||
                     (frame_commit_i && !want_cfg && multi_rise); // RULE24
      input_error_o <= input_fault_i || (input_error_o && !go_clr); // RULE20
      move_complete_o <= move_done_i || (move_complete_o && !go_clr && !go_pre); // RULE21
      // the two-word range only limits the multi-word format
      pos_invalid_o <= (pos_ovf && !in_fmt_32_o) || (pos_invalid_o && !go_pre); // RULE10 RULE21
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_from_feedback_o <= 1'b0;
      run_stored_sequence_o <= 1'b0;
      clear_errors_o <= 1'b0;
      preset_position_o <= 1'b0;
      jog_counterclockwise_o <= 1'b0;
      jog_registration_o <= 1'b0;
      axis_follower_o <= 1'b0;
      seq_dwell_o <= 1'b0;
      seq_ccw_o <= 1'b0;
      dwell_ms_o <= 16'h0000;
      preset_src_fb_o <= 1'b0;
      param_value_o <= 32'h0000_0000;
      status_word0_o <= 16'h0000;
      pos_word_first_o <= 16'h0000;
      pos_word_second_o <= 16'h0000;
    end else begin
      load_from_feedback_o <= go_load; // RULE17
      run_stored_sequence_o <= go_run; // RULE18
      clear_errors_o <= go_clr; // RULE20
      preset_position_o <= go_pre; // RULE21
      jog_counterclockwise_o <= go_jog && !reg_mv && !follow; // RULE22
      jog_registration_o <= go_jog && reg_mv; // RULE22
      axis_follower_o <= go_jog && follow; // RULE22
      if (go_run) begin
        seq_dwell_o <= c1[MCWD_B1_SEQ_TYPE]; // RULE18
        seq_ccw_o <= c1[MCWD_B1_BLEND_DIR]; // RULE19
        dwell_ms_o <= w[MCWD_IDX_DWELL]; // RULE15
      end
      if (go_pre) begin
        preset_src_fb_o <= c1[MCWD_B1_PRESET_SRC]; // RULE21
      end
      if (go_load || go_pre) begin
        param_value_o <= (out_fmt_32_o && !big_endian_o) ? {par32[15:0], par32[31:16]}
                       : par32; // RULE11
      end
      status_word0_o <= cfg_mode_o ? cfg_mirror_rd : next_status0; // RULE1
      pos_word_first_o <= in_fmt_32_o ? b_first : mw_first;
      pos_word_second_o <= in_fmt_32_o ? b_second : mw_second;
    end
  end
endmodule // mcwd_top

// ### hdl/mcwd_pkg.sv
/*
  constants for the motion command word decoder: word indices, bit positions,
  configuration field layout, limits and the encodings of the word formats.
  assumes one 16-bit word is presented per write strobe, indexed 0 to 9.
*/
package mcwd_pkg;
  localparam int unsigned MCWD_NUM_WORDS = 10;
  localparam int unsigned MCWD_WORD_W = 16;
  localparam int unsigned MCWD_IDX_W = 4;
  // word indices
  localparam logic [3:0] MCWD_IDX_CMD0 = 4'h0;
  localparam logic [3:0] MCWD_IDX_CMD1 = 4'h1;
  localparam logic [3:0] MCWD_IDX_PAR_HI = 4'h2;
  localparam logic [3:0] MCWD_IDX_PAR_LO = 4'h3;
  localparam logic [3:0] MCWD_IDX_SPD_HI = 4'h2;
  localparam logic [3:0] MCWD_IDX_SPD_LO = 4'h3;
  localparam logic [3:0] MCWD_IDX_ENC_RES = 4'h6;
  localparam logic [3:0] MCWD_IDX_DWELL = 4'h9;
  // command word 0 bits
  localparam int unsigned MCWD_B0_MODE = 15;
  localparam int unsigned MCWD_B0_LOAD_FB = 14;
  localparam int unsigned MCWD_B0_RUN_SEQ = 13;
  localparam int unsigned MCWD_B0_CLR_ERR = 10;
  localparam int unsigned MCWD_B0_PRESET = 9;
  localparam int unsigned MCWD_B0_JOG_COUNTERCLOCKWISE = 8;
  localparam int unsigned MCWD_CMD_BITS = 15;
  // command word 1 bits
  localparam int unsigned MCWD_B1_ENC_FOLLOW = 14;
  localparam int unsigned MCWD_B1_PRESET_SRC = 13;
  localparam int unsigned MCWD_B1_POS_FOLLOW = 12;
  localparam int unsigned MCWD_B1_SEQ_TYPE = 9;
  localparam int unsigned MCWD_B1_REG_MOVE = 7;
  localparam int unsigned MCWD_B1_BLEND_DIR = 4;
  localparam int unsigned MCWD_B1_INFMT = 9;
  localparam int unsigned MCWD_B1_OUTFMT = 8;
  localparam int unsigned MCWD_B1_ENDIAN = 7;
  // configuration word 0 layout
  localparam int unsigned MCWD_C0_STALL = 13;
  localparam int unsigned MCWD_C0_ENC_USE = 12;
  localparam int unsigned MCWD_C0_IN2_LSB = 3;
  localparam int unsigned MCWD_C0_IN1_LSB = 0;
  localparam int unsigned MCWD_FUNC_W = 3;
  localparam logic [15:0] MCWD_C0_RSV_MASK = 16'h0FC0;
  localparam logic [15:0] MCWD_C1_RSV_MASK = 16'h707C;
  localparam logic [2:0] MCWD_FUNC_GP = 3'h0;
  localparam logic [2:0] MCWD_FUNC_BAD = 3'h7;
  // limits and formats
  localparam logic [15:0] MCWD_SPD_LO_MAX = 16'h03E7;
  localparam logic [15:0] MCWD_RES_1K = 16'h0400;
  localparam logic [15:0] MCWD_RES_2K = 16'h0800;
  localparam logic [15:0] MCWD_RES_4K = 16'h1000;
  localparam logic signed [31:0] MCWD_SCALE = 32'sd1000;
  localparam logic signed [31:0] MCWD_MW_MIN = -32'sd32768000;
  localparam logic signed [31:0] MCWD_MW_MAX = 32'sd32767999;
  localparam logic [15:0] MCWD_IND_WORD = 16'hFFFF;
  typedef enum logic [1:0] {MCWD_CMD_ONLY, MCWD_CFG_ONLY} mcwd_mode_t;
endpackage

// ### hdl/mcwd_word_mem.sv
/*
  ten-word image memory with a registered read port.
  assumes a single clock and writes of one word at a time.
*/
`timescale 1ns/1ns
module mcwd_word_mem
  import mcwd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [3:0] rd_idx_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [MCWD_NUM_WORDS];

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < MCWD_NUM_WORDS; i++) begin
        mem[i] <= 16'h0000;
      end
      rd_data_o <= 16'h0000;
    end else begin
      if (wr_en_i && (wr_idx_i < 4'hA)) begin
        mem[wr_idx_i] <= wr_data_i;
      end
      rd_data_o <= (rd_idx_i < 4'hA) ? mem[rd_idx_i] : 16'h0000;
    end
  end
endmodule // mcwd_word_mem

// ### verification/mcwd_top_sva.sv
/*
  concurrent checks on the decoder ports, bound into mcwd_top.
  assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ns
module mcwd_top_sva
  import mcwd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic frame_commit_i,
  input wire logic move_done_i,
  input wire logic signed [31:0] motor_pos_i,
  input wire logic cfg_mode_o,
  input wire logic cfg_error_o,
  input wire logic cmd_error_o,
  input wire logic move_complete_o,
  input wire logic [15:0] status_word0_o,
  input wire logic [15:0] pos_word_first_o,
  input wire logic in_fmt_32_o,
  input wire logic big_endian_o,
  input wire logic load_from_feedback_o,
  input wire logic run_stored_sequence_o,
  input wire logic clear_errors_o,
  input wire logic preset_position_o,
  input wire logic jog_counterclockwise_o,
  input wire logic jog_registration_o,
  input wire logic axis_follower_o
);
  logic [6:0] pulses;
  logic signed [31:0] pos_q;
  assign pulses = {load_from_feedback_o, run_stored_sequence_o, clear_errors_o,
    preset_position_o, jog_counterclockwise_o, jog_registration_o, axis_follower_o};
  always_ff @(posedge clk_sys_i) pos_q <= motor_pos_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_one_cmd: assert property ($onehot0(pulses))
    else $error("more than one command pulse");
  a_pulse_cause: assert property (|pulses |-> $past(frame_commit_i))
    else $error("command pulse without a commit");
  a_pulse_short: assert property (|pulses |=> !(|pulses))
    else $error("command pulse longer than one cycle");
  a_stat_cfgerr: assert property ((!cfg_mode_o && !$past(cfg_mode_o)) |->
    status_word0_o[13] == $past(cfg_error_o)) else $error("status bit 13 not config error");
  a_stat_mode: assert property ((cfg_mode_o && $past(cfg_mode_o)) |-> status_word0_o[15])
    else $error("status bit 15 clear in config mode");
  a_clr_keeps: assert property (clear_errors_o |-> !cmd_error_o && $stable(cfg_error_o))
    else $error("clear left command error or touched config error");
  a_clr_done: assert property ((clear_errors_o && !$past(move_done_i)) |-> !move_complete_o)
    else $error("clear left move complete");
  a_preset_done: assert property ((preset_position_o && !$past(move_done_i)) |->
    !move_complete_o) else $error("preset left move complete");
  a_pos_ovf: assert property ((!in_fmt_32_o && !$past(in_fmt_32_o) && $stable(motor_pos_i) &&
    (pos_q > MCWD_MW_MAX || pos_q < MCWD_MW_MIN)) |-> pos_word_first_o == MCWD_IND_WORD)
    else $error("overflow position word not marked");
  a_big_endian: assert property ((in_fmt_32_o && big_endian_o && $past(in_fmt_32_o) &&
    $stable(big_endian_o) && $stable(motor_pos_i)) |-> pos_word_first_o == pos_q[31:16])
    else $error("big endian first word not high half");
  c_registration: cover property (jog_registration_o);
  c_cfg_entered: cover property ($rose(cfg_mode_o));
  c_cmd_error: cover property ($rose(cmd_error_o));
endmodule // mcwd_top_sva
bind mcwd_top mcwd_top_sva i_mcwd_top_sva (.clk_sys_i, .rst_b_i, .frame_commit_i, .move_done_i,
  .motor_pos_i, .cfg_mode_o, .cfg_error_o, .cmd_error_o, .move_complete_o, .status_word0_o,
  .pos_word_first_o, .in_fmt_32_o, .big_endian_o, .load_from_feedback_o, .run_stored_sequence_o,
  .clear_errors_o, .preset_position_o, .jog_counterclockwise_o, .jog_registration_o,
  .axis_follower_o);

// ### verification/mcwd_host_model.sv
/*
  host side: writes the ten-word image one word per cycle, then one commit.
  assumes go_i is a one-cycle pulse given while idle.
*/
`timescale 1ns/1ns
module mcwd_host_model (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [159:0] img_i,
  output logic word_wr_o = 1'b0,
  output logic [3:0] word_idx_o = 4'h0,
  output logic [15:0] word_data_o = 16'h0000,
  output logic frame_commit_o = 1'b0
);
  logic [4:0] cnt = 5'h1F;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 5'h1F;
      word_wr_o <= 1'b0;
      frame_commit_o <= 1'b0;
    end else begin
      word_wr_o <= (cnt < 5'h0A);
      word_idx_o <= cnt[3:0];
      // idle data line toggles every cycle, starting from the inverse of the last word
      word_data_o <= (cnt < 5'h0A) ? img_i[{cnt[3:0], 4'h0} +: 16] : ~word_data_o;
      frame_commit_o <= (cnt == 5'h0A);
      cnt <= go_i ? 5'h00 : ((cnt < 5'h0B) ? cnt + 5'h01 : cnt);
    end
  end
endmodule // mcwd_host_model

// ### verification/tb_top.sv
/*
  bench: frames through the host model, a behavioural decoder model, compares.
  assumes mcwd_pkg and the host model.
*/
`timescale 1ns/1ns
module tb_top
  import mcwd_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic go = 1'b0;
  logic enc_absolute_i = 1'b0;
  logic move_done_i = 1'b0;
  logic input_fault_i = 1'b0;
  logic signed [31:0] motor_pos_i = 32'h00000000;
  logic [159:0] img = '0;
  logic word_wr_i, frame_commit_i, cfg_mode_o, cfg_error_o, cmd_error_o, input_error_o, seq_ccw_o;
  logic move_complete_o, pos_invalid_o, out_fmt_32_o, in_fmt_32_o, big_endian_o, seq_dwell_o;
  logic load_from_feedback_o, run_stored_sequence_o, clear_errors_o, preset_position_o;
  logic preset_src_fb_o, jog_counterclockwise_o, jog_registration_o, axis_follower_o;
  logic [3:0] word_idx_i;
  logic [15:0] word_data_i, status_word0_o, pos_word_first_o, pos_word_second_o, dwell_ms_o;
  logic [31:0] param_value_o;
  logic [31:0] seed = 32'h0000B8FC;
  logic cfg_m = 1'b0, cfg_e = 1'b0, cmd_e = 1'b0, ie_m = 1'b0, mc_m = 1'b0, pi_m = 1'b0;
  logic if_m = 1'b0, of_m = 1'b0, be_m = 1'b0;
  logic [14:0] prev = 15'h0000;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [15:0] CMDS [16] = '{16'h0000, 16'h4000, 16'h0000, 16'h2000, 16'h2000,
    16'h0000, 16'h0300, 16'h0000, 16'h0400, 16'h0000, 16'h0200, 16'h0100, 16'h0000, 16'h0100,
    16'h0000, 16'h0010};
  localparam logic [63:0] CFGS [10] = '{64'h8040000000000000, 64'h8000000400000000,
    64'h8000000003E80000, 64'h8009000000000000, 64'h8000000003E70000, 64'h8007000000000000,
    64'hA000000000000000, 64'h9000000000000C00, 64'h9000000000000400, 64'hB011000003E70800};
  localparam logic [31:0] POS [5] = '{32'h0012D687, 32'hFF8B344F, 32'h01F3FFFF, 32'hFE0C0000,
    32'h01F40000};
  always #4 clk_sys_i = ~clk_sys_i;
  mcwd_host_model i_mcwd_host_model (.clk_sys_i, .rst_b_i, .go_i(go), .img_i(img),
    .word_wr_o(word_wr_i), .word_idx_o(word_idx_i), .word_data_o(word_data_i),
    .frame_commit_o(frame_commit_i));
  mcwd_top i_mcwd_top (.clk_sys_i, .rst_b_i, .word_wr_i, .word_idx_i, .word_data_i,
    .frame_commit_i, .enc_absolute_i, .move_done_i, .input_fault_i, .motor_pos_i, .cfg_mode_o,
    .cfg_error_o, .cmd_error_o, .input_error_o, .move_complete_o, .pos_invalid_o,
    .status_word0_o, .pos_word_first_o, .pos_word_second_o, .out_fmt_32_o, .in_fmt_32_o,
    .big_endian_o, .load_from_feedback_o, .run_stored_sequence_o, .seq_dwell_o, .seq_ccw_o,
    .dwell_ms_o, .clear_errors_o, .preset_position_o, .preset_src_fb_o, .jog_counterclockwise_o,
    .jog_registration_o, .axis_follower_o, .param_value_o);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w3,
      input logic [15:0] w6);
    logic [159:0] v;
    logic [14:0] rise;
    logic [6:0] ep;
    logic [31:0] r;
    int n;
    r = rnd();
    v = {r, rnd(), rnd(), rnd(), rnd()};
    v[31:0] = {w1, w0};
    v[63:48] = w3;
    v[111:96] = w6;
    @(posedge clk_sys_i);
    {move_done_i, input_fault_i, go} <= {r[0], r[1], 1'b1};
    @(posedge clk_sys_i);
    img <= v;
    {move_done_i, input_fault_i, go} <= 3'b000;
    {mc_m, ie_m} = {mc_m | r[0], ie_m | r[1]};
    rise = w0[14:0] & ~prev;
    prev = w0[14:0];
    ep = 7'h00;
    if (w0[15]) begin
      if (!(w0 & 16'h0FC0) && !(w1 & 16'h707C) && w3 <= 16'h03E7 && w0[2:0] != 3'h7 &&
          w0[5:3] != 3'h7 && (w0[2:0] != w0[5:3] || w0[2:0] == 3'h0) && (!w0[13] || w0[12]) &&
          (!w0[12] || (enc_absolute_i ? w6 == 16'h0800 : w6 inside {16'h0400, 16'h0800,
          16'h1000}))) {cfg_m, cfg_e, if_m, of_m, be_m} = {2'b10, w1[9:7]};
      else {cfg_m, cfg_e} = 2'b01;
    end else begin
      cfg_m = 1'b0;
      if ($countones(rise) > 1) cmd_e = 1'b1;
      else ep = {rise[14:13], rise[10:9], rise[8] & ~w1[7] & ~(w1[12] | w1[14]),
        rise[8] & w1[7], rise[8] & ~w1[7] & (w1[12] | w1[14])};
      if (ep[4]) {cmd_e, ie_m, mc_m} = 3'b000;
      if (ep[3]) {mc_m, pi_m} = 2'b00;
    end
    n = 0;
    while (frame_commit_i !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40) bad_count++;
    #1;
    chk(32'({load_from_feedback_o, run_stored_sequence_o, clear_errors_o, preset_position_o,
      jog_counterclockwise_o, jog_registration_o, axis_follower_o}), 32'(ep));
    chk(32'({cfg_mode_o, cfg_error_o, cmd_error_o, input_error_o, move_complete_o, in_fmt_32_o,
      out_fmt_32_o, big_endian_o}), 32'({cfg_m, cfg_e, cmd_e, ie_m, mc_m, if_m, of_m, be_m}));
    if (ep[5]) chk(32'({seq_dwell_o, seq_ccw_o, dwell_ms_o}), 32'({w1[9], w1[4], v[159:144]}));
    if (ep[3]) chk(32'(preset_src_fb_o), 32'(w1[13]));
    if (ep[6] || ep[3]) chk(param_value_o, (of_m && !be_m) ? {w3, v[47:32]} : {v[47:32], w3});
    @(posedge clk_sys_i);
    #1;
    chk(32'(status_word0_o), 32'(cfg_m ? w0 : {2'b00, cfg_e, cmd_e, ie_m, mc_m, pi_m, 9'h000}));
  endtask
  task automatic pos_chk(input logic signed [31:0] p);
    logic [31:0] e;
    @(posedge clk_sys_i);
    motor_pos_i <= p;
    repeat (3) @(posedge clk_sys_i);
    #1;
    if (if_m) e = be_m ? p : {p[15:0], p[31:16]};
    else if (p > 32'sh01F3FFFF || p < 32'shFE0C0000) {e, pi_m} = {32'hFFFFFFFF, 1'b1};
    else e = {16'(p / 32'sh000003E8), 16'(p % 32'sh000003E8)};
    chk({pos_word_first_o, pos_word_second_o}, e);
    chk(32'(pos_invalid_o), 32'(pi_m));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // a full run is some 800 cycles
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 32; i++) send(CMDS[i % 16], 16'(rnd()), 16'(rnd()), 16'(rnd()));
    $display("commands test done");
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys_i);
      enc_absolute_i <= (i > 7);
      send(CFGS[i][63:48], CFGS[i][47:32], CFGS[i][31:16], CFGS[i][15:0]);
    end
    send(16'h3000, 16'h0000, 16'h0000, 16'h0000);
    $display("configuration test done");
    for (int i = 0; i < 12; i++) pos_chk(i < 5 ? POS[i] : $signed(rnd()) % 32'sh01E84800);
    pos_chk(32'sh00000000);
    $display("multi-word test done");
    send(16'h8000, 16'h0280, 16'h0000, 16'h0000);
    for (int i = 0; i < 3; i++) pos_chk($signed(rnd()));
    send(16'h8000, 16'h0300, 16'h0000, 16'h0000);
    for (int i = 0; i < 3; i++) pos_chk($signed(rnd()));
    send(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    send(16'h0200, 16'h0000, 16'h0000, 16'h0000);
    $display("format test done");
    final_report();
  end
endmodule // tb_top
